// >>> cwl_regs.vh
// Notes on behaviour
// RULE1: programmed configuration bit reads 0, unprogrammed bit reads 1.
// RULE2: configuration bits appear from table address f80000 upward.
// RULE3: addresses 800000 to ffffff answer only table reads and writes.
// RULE4: configuration registers are volatile and copied from flash on every reset.
// RULE5: reload happens on every reset source, not just power-up.
// RULE6: word 1 sits at abfe (small) or 157fe (large); others lower, even.
// RULE7: upper byte of each word carries no configuration and has no effect.
// RULE8: erased last page clears words, so protection turns on at next load.
// RULE9: word 1 bits 23 to 16 always read as one.
// RULE10: bit 15 is reserved; software programs it as zero.
// RULE11: bit 14 high enables the boundary-scan port.
// RULE12: bit 13 low protects all program memory.
// RULE13: bit 12 low blocks every program memory write.
// RULE14: bit 11 low makes the device leave reset in debug mode.
// RULE15: bit 10 high keeps retention regulator off; low gives firmware control.
// RULE16: bits 9-8 pick emulator pin pair: 11 pair1, 10 pair2, 01 pair3.
// RULE17: bit 7 high standard watchdog, low windowed; windowed never with mode 00.
// RULE18: watchdog mode 11 always runs; software enable ignored.
// RULE19: watchdog mode 10 follows the software enable.
// RULE20: watchdog mode 01 runs only in run mode; software enable ignored.
// RULE21: watchdog mode 00 disables the watchdog.
// RULE22: bit 4 high prescale 1:128, low 1:32.
// RULE23: bits 3-0 select postscale 1:2^n.
// RULE24: hold core and units in reset until all words are latched.
`ifndef CWL_REGS_VH
`define CWL_REGS_VH
`define CWL_CFG_BASE 24'hf80000
`define CWL_CFG_SPACE_LO 24'h800000
`define CWL_WORD1_SMALL 24'h00abfe
`define CWL_WORD1_LARGE 24'h0157fe
`define CWL_WORD_STEP 24'h000002
`define CWL_NUM_WORDS 3'h4
`define CWL_LAST_WORD 2'h3
`define CWL_ERASED 24'hffffff
`define CWL_UNIMP_HI 8'hff
`define CWL_BIT_SCAN 14
`define CWL_BIT_CP 13
`define CWL_BIT_WP 12
`define CWL_BIT_DBG 11
`define CWL_BIT_REG 10
`define CWL_ICS_HI 9
`define CWL_ICS_LO 8
`define CWL_BIT_WIN 7
`define CWL_WDM_HI 6
`define CWL_WDM_LO 5
`define CWL_BIT_PSA 4
`define CWL_PS_HI 3
`define CWL_PS_LO 0
`define CWL_WDM_ALWAYS 2'h3
`define CWL_WDM_SW 2'h2
`define CWL_WDM_RUN 2'h1
`define CWL_WDM_OFF 2'h0
`define CWL_ICS_PAIR1 2'h3
`define CWL_ICS_PAIR2 2'h2
`define CWL_ICS_PAIR3 2'h1
`define CWL_PRE_128 8'h80
`define CWL_PRE_32 8'h20
`endif

// >>> cwl_word1_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "cwl_regs.vh"
module cwl_word1_decode (
  // latched word 1
  input wire [23:0] word,
  // firmware / mode
  input wire sw_wdt_en,
  input wire retention_enable,
  input wire in_sleep,
  // decoded
  output wire scan_en,
  output wire code_prot,
  output wire write_blk,
  output wire debug_boot,
  output wire reg_on,
  output wire [2:0] pin_pair,
  output wire window_en,
  output wire wdt_run,
  output wire [7:0] prescale,
  output wire [15:0] postscale
);
  wire [1:0] wdm;
  wire [1:0] emulator_pin_select;
  assign wdm = word[`CWL_WDM_HI:`CWL_WDM_LO];
  assign emulator_pin_select = word[`CWL_ICS_HI:`CWL_ICS_LO];
  assign scan_en = word[`CWL_BIT_SCAN]; // RULE11
  assign code_prot = ~word[`CWL_BIT_CP]; // RULE12
  assign write_blk = ~word[`CWL_BIT_WP]; // RULE13
  assign debug_boot = ~word[`CWL_BIT_DBG]; // RULE14
  assign reg_on = ~word[`CWL_BIT_REG] & retention_enable; // RULE15
  // reserved code 00 routes to no pair
  assign pin_pair = {emulator_pin_select == `CWL_ICS_PAIR3, emulator_pin_select == `CWL_ICS_PAIR2,
                     emulator_pin_select == `CWL_ICS_PAIR1}; // RULE16
  // windowed mode forced off with mode 00 so a bad image cannot arm it
  assign window_en = ~word[`CWL_BIT_WIN] & (wdm != `CWL_WDM_OFF); // RULE17
  assign wdt_run = (wdm == `CWL_WDM_ALWAYS) | // RULE18
                   ((wdm == `CWL_WDM_SW) & sw_wdt_en) | // RULE19
                   ((wdm == `CWL_WDM_RUN) & ~in_sleep); // RULE20 RULE21
  assign prescale = word[`CWL_BIT_PSA] ? `CWL_PRE_128 : `CWL_PRE_32; // RULE22
  assign postscale = 16'h0001 << word[`CWL_PS_HI:`CWL_PS_LO]; // RULE23
endmodule
`default_nettype wire

// >>> cwl_loader.v
`timescale 1ns/1ps
`default_nettype none
`include "cwl_regs.vh"
module cwl_loader (
  // clock and reset
  input wire CORE_CLK,
  input wire NRST,
  // reset controller: any reset source, level high while asserted
  input wire DEV_RESET,
  input wire LARGE_MEM,
  // flash read port, one cycle latency
  output reg [23:0] FLASH_ADDR,
  output reg FLASH_RD,
  input wire [23:0] FLASH_DATA,
  // table access into configuration space
  input wire TBL_RD,
  input wire [23:0] TBL_ADDR,
  output reg [23:0] TBL_RDATA,
  input wire FETCH_VALID,
  input wire [23:0] FETCH_ADDR,
  output reg FETCH_CFG_BLOCK,
  // firmware / mode
  input wire SW_WDT_EN,
  input wire RETENTION_EN,
  input wire IN_SLEEP,
  // reset sequencing
  output reg HOLD_RESET,
  output reg LOAD_DONE,
  // decoded configuration
  output reg SCAN_EN,
  output reg CODE_PROT,
  output reg WRITE_BLK,
  output reg DEBUG_BOOT,
  output reg REG_ON,
  output reg [2:0] PIN_PAIR,
  output reg WINDOW_EN,
  output reg WDT_RUN,
  output reg [7:0] PRESCALE,
  output reg [15:0] POSTSCALE
);
  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_DONE = 2'h2;
  reg [1:0] st_q;
  reg [1:0] idx_q;
  reg pend_q;
  reg [23:0] words_q [0:3];
  wire [23:0] word1_img;
  wire scan_en;
  wire code_prot;
  wire write_blk;
  wire debug_boot;
  wire reg_on;
  wire [2:0] pin_pair;
  wire window_en;
  wire wdt_run;
  wire [7:0] prescale;
  wire [15:0] postscale;
  wire [23:0] base;
  wire [23:0] tbl_off;
  // ==========================================
  // load sequencer
  assign base = LARGE_MEM ? `CWL_WORD1_LARGE : `CWL_WORD1_SMALL; // RULE6
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      st_q <= ST_IDLE;
      idx_q <= 2'h0;
      pend_q <= 1'b0;
      FLASH_ADDR <= 24'h000000;
      FLASH_RD <= 1'b0;
      HOLD_RESET <= 1'b1;
      LOAD_DONE <= 1'b0;
    end else begin
      pend_q <= FLASH_RD;
      if (DEV_RESET) begin
        // every reset source restarts the copy
        st_q <= ST_READ; // RULE4 RULE5
        idx_q <= 2'h0;
        FLASH_ADDR <= base;
        FLASH_RD <= 1'b1;
        HOLD_RESET <= 1'b1; // RULE24
        LOAD_DONE <= 1'b0;
        pend_q <= 1'b0;
      end else begin
        case (st_q)
          ST_IDLE: begin
            st_q <= ST_READ;
            FLASH_ADDR <= base;
            FLASH_RD <= 1'b1;
          end
          ST_READ: begin
            if (pend_q) begin
              if (idx_q == `CWL_LAST_WORD) begin
                st_q <= ST_DONE;
                FLASH_RD <= 1'b0;
              end else begin
                idx_q <= idx_q + 2'h1;
                FLASH_ADDR <= FLASH_ADDR - `CWL_WORD_STEP; // RULE6
                FLASH_RD <= 1'b1;
              end
            end else begin
              FLASH_RD <= 1'b0;
            end
          end
          ST_DONE: begin
            HOLD_RESET <= 1'b0; // RULE24
            LOAD_DONE <= 1'b1;
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end
  // ==========================================
  // volatile configuration copies
  genvar gi;
  generate
    for (gi = 0; gi < `CWL_NUM_WORDS; gi = gi + 1) begin : g_word
      always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
          // unprogrammed state reads as ones
          words_q[gi] <= `CWL_ERASED; // RULE1
        end else if (st_q == ST_READ && pend_q && !DEV_RESET && idx_q == gi) begin
          // an erased page yields zeros, so protection turns on by itself
          words_q[gi] <= FLASH_DATA; // RULE4 RULE8
        end
      end
    end
  endgenerate
  // upper byte is ignored and read back as ones
  assign word1_img = {`CWL_UNIMP_HI, words_q[0][15:0]}; // RULE7 RULE9
  // ==========================================
  // word 1 decode
  cwl_word1_decode u_dec (
    .word(word1_img),
    .sw_wdt_en(SW_WDT_EN),
    .retention_enable(RETENTION_EN),
    .in_sleep(IN_SLEEP),
    .scan_en(scan_en),
    .code_prot(code_prot),
    .write_blk(write_blk),
    .debug_boot(debug_boot),
    .reg_on(reg_on),
    .pin_pair(pin_pair),
    .window_en(window_en),
    .wdt_run(wdt_run),
    .prescale(prescale),
    .postscale(postscale)
  );
  // outputs stay safe (protected, watchdog off) until the load is done
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      SCAN_EN <= 1'b0;
      CODE_PROT <= 1'b1;
      WRITE_BLK <= 1'b1;
      DEBUG_BOOT <= 1'b0;
      REG_ON <= 1'b0;
      PIN_PAIR <= 3'h0;
      WINDOW_EN <= 1'b0;
      WDT_RUN <= 1'b0;
      PRESCALE <= `CWL_PRE_32;
      POSTSCALE <= 16'h0001;
    end else if (DEV_RESET || st_q != ST_DONE) begin
      // a restart falls back to the safe set, so the old image never rules a reload
      SCAN_EN <= 1'b0;
      CODE_PROT <= 1'b1; // RULE24
      WRITE_BLK <= 1'b1; // RULE24
      DEBUG_BOOT <= 1'b0;
      REG_ON <= 1'b0;
      PIN_PAIR <= 3'h0;
      WINDOW_EN <= 1'b0;
      WDT_RUN <= 1'b0;
      PRESCALE <= `CWL_PRE_32;
      POSTSCALE <= 16'h0001;
    end else begin
      SCAN_EN <= scan_en; // RULE11
      CODE_PROT <= code_prot; // RULE12
      WRITE_BLK <= write_blk; // RULE13
      DEBUG_BOOT <= debug_boot; // RULE14
      REG_ON <= reg_on; // RULE15
      PIN_PAIR <= pin_pair; // RULE16
      WINDOW_EN <= window_en; // RULE17
      WDT_RUN <= wdt_run; // RULE18 RULE19 RULE20 RULE21
      PRESCALE <= prescale; // RULE22
      POSTSCALE <= postscale; // RULE23
    end
  end
  // ==========================================
  // table read into configuration space
  assign tbl_off = TBL_ADDR - `CWL_CFG_BASE;
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      TBL_RDATA <= `CWL_ERASED;
      FETCH_CFG_BLOCK <= 1'b0;
    end else begin
      // ordinary fetches never reach configuration space
      FETCH_CFG_BLOCK <= FETCH_VALID && FETCH_ADDR >= `CWL_CFG_SPACE_LO; // RULE3
      if (TBL_RD) begin
        if (TBL_ADDR >= `CWL_CFG_BASE && tbl_off[23:3] == 21'h0 && !tbl_off[0]) begin
          TBL_RDATA <= (tbl_off[2:1] == 2'h0) ? word1_img
                       : {`CWL_UNIMP_HI, words_q[tbl_off[2:1]][15:0]}; // RULE2 RULE3
        end else begin
          TBL_RDATA <= `CWL_ERASED; // RULE1
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> cwl_loader_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cwl_loader_checker (
  // clock, reset and sequencing
  input wire CORE_CLK,
  input wire NRST,
  input wire DEV_RESET,
  input wire LARGE_MEM,
  input wire HOLD_RESET,
  input wire LOAD_DONE,
  // flash and table ports
  input wire FLASH_RD,
  input wire [23:0] FLASH_ADDR,
  input wire TBL_RD,
  input wire [23:0] TBL_ADDR,
  input wire [23:0] TBL_RDATA,
  input wire FETCH_VALID,
  input wire [23:0] FETCH_ADDR,
  input wire FETCH_CFG_BLOCK,
  // decoded outputs
  input wire CODE_PROT,
  input wire WRITE_BLK,
  input wire [2:0] PIN_PAIR,
  input wire [7:0] PRESCALE,
  input wire [15:0] POSTSCALE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  a_fetch_blocked: assert property (FETCH_VALID |=>
    FETCH_CFG_BLOCK == ($past(FETCH_ADDR) >= 24'h800000)) else $error("fetch block wrong");
  a_tbl_refused: assert property (TBL_RD && (TBL_ADDR[23:3] != 21'h1f0000 || TBL_ADDR[0])
    |=> TBL_RDATA == 24'hffffff) else $error("table read outside window answered");
  a_upper_ones: assert property (TBL_RD |=> TBL_RDATA[23:16] == 8'hff)
    else $error("upper byte not all ones");
  a_flash_place: assert property (FLASH_RD |-> !FLASH_ADDR[0] &&
    FLASH_ADDR[23:3] == (LARGE_MEM ? 21'h2aff : 21'h157f)) else $error("flash address off");
  a_read_spacing: assert property (FLASH_RD |=> !FLASH_RD)
    else $error("flash reads back to back");
  a_hold_safe: assert property (HOLD_RESET |-> CODE_PROT && WRITE_BLK && !LOAD_DONE)
    else $error("unsafe outputs while loading");
  a_reset_reload: assert property (DEV_RESET |=> HOLD_RESET && !LOAD_DONE)
    else $error("device reset did not restart load");
  a_load_bound: assert property (HOLD_RESET && !DEV_RESET |-> ##[1:20] LOAD_DONE)
    else $error("load did not finish");
  a_scale_legal: assert property (LOAD_DONE |-> $onehot(POSTSCALE) && $onehot0(PIN_PAIR)
    && (PRESCALE == 8'h20 || PRESCALE == 8'h80)) else $error("scaler or pin code illegal");
endmodule
bind cwl_loader cwl_loader_checker u_chk (
  .CORE_CLK(CORE_CLK),
  .NRST(NRST),
  .DEV_RESET(DEV_RESET),
  .LARGE_MEM(LARGE_MEM),
  .HOLD_RESET(HOLD_RESET),
  .LOAD_DONE(LOAD_DONE),
  .FLASH_RD(FLASH_RD),
  .FLASH_ADDR(FLASH_ADDR),
  .TBL_RD(TBL_RD),
  .TBL_ADDR(TBL_ADDR),
  .TBL_RDATA(TBL_RDATA),
  .FETCH_VALID(FETCH_VALID),
  .FETCH_ADDR(FETCH_ADDR),
  .FETCH_CFG_BLOCK(FETCH_CFG_BLOCK),
  .CODE_PROT(CODE_PROT),
  .WRITE_BLK(WRITE_BLK),
  .PIN_PAIR(PIN_PAIR),
  .PRESCALE(PRESCALE),
  .POSTSCALE(POSTSCALE)
);
`default_nettype wire

// >>> cwl_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module cwl_flash_model (
  input wire clk,
  input wire rd,
  input wire [23:0] addr,
  output logic [23:0] data
);
  logic [23:0] mem [0:3];
  // word n sits 2n below the top; an idle bus shows the inverse so stale data never passes
  always @(posedge clk) data <= rd ? mem[~addr[2:1]] : ~data;
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic CORE_CLK = 0, NRST = 0, DEV_RESET = 0, LARGE_MEM = 0, TBL_RD = 0, FETCH_VALID = 1;
  logic SW_WDT_EN = 0, RETENTION_EN = 0, IN_SLEEP = 0;
  logic [23:0] TBL_ADDR = 0, FETCH_ADDR = 0, FLASH_DATA, FLASH_ADDR, TBL_RDATA, w;
  logic FLASH_RD, FETCH_CFG_BLOCK, HOLD_RESET, LOAD_DONE, SCAN_EN, CODE_PROT, WRITE_BLK;
  logic DEBUG_BOOT, REG_ON, WINDOW_EN, WDT_RUN;
  logic [2:0] PIN_PAIR;
  logic [7:0] PRESCALE;
  logic [15:0] POSTSCALE;
  int fail_count = 0, checks = 0, cyc = 0;
  always #2.5 CORE_CLK = ~CORE_CLK;
  cwl_loader u_dut (
    .CORE_CLK(CORE_CLK), .NRST(NRST), .DEV_RESET(DEV_RESET), .LARGE_MEM(LARGE_MEM),
    .FLASH_ADDR(FLASH_ADDR), .FLASH_RD(FLASH_RD), .FLASH_DATA(FLASH_DATA),
    .TBL_RD(TBL_RD), .TBL_ADDR(TBL_ADDR), .TBL_RDATA(TBL_RDATA),
    .FETCH_VALID(FETCH_VALID), .FETCH_ADDR(FETCH_ADDR), .FETCH_CFG_BLOCK(FETCH_CFG_BLOCK),
    .SW_WDT_EN(SW_WDT_EN), .RETENTION_EN(RETENTION_EN), .IN_SLEEP(IN_SLEEP),
    .HOLD_RESET(HOLD_RESET), .LOAD_DONE(LOAD_DONE),
    .SCAN_EN(SCAN_EN), .CODE_PROT(CODE_PROT), .WRITE_BLK(WRITE_BLK),
    .DEBUG_BOOT(DEBUG_BOOT), .REG_ON(REG_ON), .PIN_PAIR(PIN_PAIR),
    .WINDOW_EN(WINDOW_EN), .WDT_RUN(WDT_RUN), .PRESCALE(PRESCALE), .POSTSCALE(POSTSCALE)
  );
  cwl_flash_model u_flash (.clk(CORE_CLK), .rd(FLASH_RD), .addr(FLASH_ADDR), .data(FLASH_DATA));
  // ==========================================
  // checking
  task automatic chk(input string n, input logic [39:0] e, g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tbl(input logic [23:0] a, e);
    @(posedge CORE_CLK);
    TBL_RD <= 1;
    TBL_ADDR <= a;
    @(posedge CORE_CLK);
    TBL_RD <= 0;
    #1 chk("table", e, TBL_RDATA);
  endtask
  function automatic logic [39:0] dec(input logic [23:0] v);
    logic [1:0] m;
    m = v[6:5];
    return {v[14], !v[13], !v[12], !v[11], !v[10] & RETENTION_EN,
      v[9:8] == 3 ? 3'h1 : v[9:8] == 2 ? 3'h2 : v[9:8] == 1 ? 3'h4 : 3'h0,
      !v[7] & m != 0, m == 3 | m == 2 & SW_WDT_EN | m == 1 & !IN_SLEEP,
      v[4] ? 8'h80 : 8'h20, 16'h1 << v[3:0]};
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // stimulus
  initial begin
    w = $urandom(32'he88516dc);
    repeat (20) @(posedge CORE_CLK);
    for (int i = 0; i < 48; i++) begin
      // first pass models an erased last page: word 1 fully programmed, others keep ones in bits 15 to 0
      w = i ? {8'h00, 1'b0, 15'($urandom)} : 24'h0;
      w[6:5] = i[1:0];
      w[9:8] = i[3:2];
      // software keeps windowed mode away from mode 00; only the erased page breaks it
      if (i[1:0] == 2'h0 && i != 0) w[7] = 1'b1;
      for (int k = 0; k < 4; k++) u_flash.mem[k] = k ? {8'h00, ~w[15:0]} : w;
      @(posedge CORE_CLK);
      {LARGE_MEM, SW_WDT_EN, RETENTION_EN, IN_SLEEP, FETCH_VALID} <= 5'($urandom);
      FETCH_ADDR <= 24'($urandom);
      if (i == 0) NRST <= 1;
      else DEV_RESET <= 1;
      @(posedge CORE_CLK);
      DEV_RESET <= 0;
      #1;
      repeat (40) if (LOAD_DONE !== 1) @(posedge CORE_CLK) #1;
      chk("hold_done", 2'b01, {HOLD_RESET, LOAD_DONE});
      @(posedge CORE_CLK) #1;
      chk("decode", dec(w), {SCAN_EN, CODE_PROT, WRITE_BLK, DEBUG_BOOT, REG_ON, PIN_PAIR,
        WINDOW_EN, WDT_RUN, PRESCALE, POSTSCALE});
      chk("fetch", FETCH_VALID && FETCH_ADDR >= 24'h800000, FETCH_CFG_BLOCK);
      tbl(24'hf80000, {8'hff, w[15:0]});
      tbl(24'hf80002, {8'hff, ~w[15:0]});
      tbl(i[1] ? 24'hf80006 : 24'hf80004, {8'hff, ~w[15:0]});
      tbl(i[0] ? 24'hf80008 : 24'hf80001, 24'hffffff);
    end
    summarize();
  end
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      summarize();
    end
  end
endmodule
`default_nettype wire
